// ---- rrt_pkg.sv ----
// Package: opcodes, field positions and widths for the transfer decoder
package rrt_pkg;
	localparam int RRT_IW = 10;
	localparam int RRT_NW = 4;
	localparam int RRT_EW = 8;
	localparam int RRT_ZW = 2;
	localparam int RRT_SW = 3;
	localparam int RRT_RAM_AW = 10;

	localparam logic [9:0] OP_COPY_B_TO_ACC    = 10'h01e;
	localparam logic [9:0] OP_COPY_ACC_TO_B    = 10'h00e;
	localparam logic [9:0] OP_COPY_ROW_TO_ACC  = 10'h01f;
	localparam logic [9:0] OP_COPY_ACC_TO_ROW  = 10'h00c;
	localparam logic [9:0] OP_PACK_TO_E        = 10'h01a;
	localparam logic [9:0] OP_COPY_BANK_TO_ACC = 10'h053;
	localparam logic [9:0] OP_COPY_COL_TO_ACC  = 10'h052;
	localparam logic [9:0] OP_COPY_STACK_LEVEL = 10'h050;
	localparam logic [9:0] OP_INCREMENT_ROW    = 10'h013;
	localparam logic [9:0] OP_DECREMENT_ROW    = 10'h017;

	// Upper opcode bits of the forms carrying an immediate
	localparam logic [1:0] PFX_LOAD_PAIR       = 2'h3;
	localparam logic [7:0] PFX_LOAD_BANK       = 8'h12;
	localparam logic [5:0] PFX_MEM_LOAD        = 6'h2c;
	localparam logic [5:0] PFX_MEM_EXCH        = 6'h2d;
	localparam logic [5:0] PFX_MEM_EXCH_DEC    = 6'h2f;
	localparam logic [5:0] PFX_MEM_EXCH_INC    = 6'h2e;
	localparam logic [5:0] PFX_MEM_STORE       = 6'h2b;

	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic [3:0] NIB_ONE  = 4'h1;
	localparam logic [3:0] NIB_MAX  = 4'hf;
	localparam logic [1:0] TWO_ZERO = 2'h0;
	localparam logic       BIT_ZERO = 1'b0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// ---- rrt_mem_if.sv ----
// Interface: data memory access port between decoder and memory
`timescale 1ns/1ns
interface rrt_mem_if;
	logic [9:0] addr;
	logic       wr_en;
	logic [3:0] wr_data;
	logic [3:0] rd_data;
	modport master (output addr, output wr_en, output wr_data,
		input rd_data);
	modport slave (input addr, input wr_en, input wr_data,
		output rd_data);
endinterface

// ---- rrt_mem.sv ----
// Data memory of nibbles with registered read data
`timescale 1ns/1ns
module rrt_mem
	import rrt_pkg::*;
#(
	parameter int DEPTH = 1024
) (
	input  wire logic i_clk,
	rrt_mem_if.slave  mem
);
	logic [3:0] store [DEPTH];
	logic [3:0] rd_q;

	initial begin
		if (DEPTH > (1 << RRT_RAM_AW))
			$error("rrt_mem: depth exceeds address range");
	end

	// Read data registered; reads the old nibble on a write cycle
	always_ff @(posedge i_clk) begin
		if (mem.wr_en)
			store[mem.addr] <= mem.wr_data;
		rd_q <= store[mem.addr];
	end

	assign mem.rd_data = rd_q;
endmodule

// ---- rrt_top.sv ----
// Top: decoder and executor of register and memory transfer instructions
// ----------------------------------------------------------------------
// Summary of operation
// - Bank copy puts Z in acc bits 1..0, clears bits 3..2.
// - Stack level copy puts level in acc bits 2..0, bit 3 zero.
// - Load pointer pair writes its two nibbles into X and Y.
// - Load bank writes two low opcode bits into Z.
// - Increment row adds one to Y modulo sixteen.
// - Decrement row subtracts one from Y modulo sixteen.
// - Memory load copies memory to acc, X gets X xor immediate.
// - Memory exchange swaps acc and memory, X gets X xor immediate.
// - Exchange with decrement also lowers Y by one.
// - Exchange with increment also raises Y by one.
// - Memory store writes acc to memory, X gets X xor immediate.
// - Copy B to acc loads acc from B.
// - Copy acc to B loads B from acc.
// - Copy row to acc loads acc from Y.
// - Copy acc to row loads Y from acc.
// - Pack to E: B into upper nibble, acc into lower nibble.
// - Y incremented to zero skips the next instruction.
// - Y decremented to fifteen skips the next instruction.
// - Back to back pointer pair loads: only the first executes.
// ----------------------------------------------------------------------
`timescale 1ns/1ns
module rrt_top
	import rrt_pkg::*;
#(
	parameter int RAM_DEPTH = 1024
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_instr_valid,
	input  wire logic [9:0] i_instr,
	input  wire logic [2:0] i_stack_level,
	input  wire logic       i_carry_flag,
	output logic      [3:0] o_acc,
	output logic      [3:0] o_reg_b,
	output logic      [3:0] o_col,
	output logic      [3:0] o_row,
	output logic      [1:0] o_bank,
	output logic      [7:0] o_reg_e,
	output logic            o_carry_flag,
	output logic            o_skip_next,
	output logic            o_busy
);
	// ------------------------------------------------------------------
	// State and memory
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {RRT_FETCH, RRT_MEMWAIT} rrt_state_e;

	rrt_state_e state_q;
	rrt_state_e state_d;
	logic [3:0] acc_q, acc_d;
	logic [3:0] b_q, b_d;
	logic [3:0] x_q, x_d;
	logic [3:0] y_q, y_d;
	logic [1:0] z_q, z_d;
	logic [7:0] e_q, e_d;
	logic       carry_q;
	logic       skip_q, skip_d;
	logic       last_pair_q, last_pair_d;
	logic       busy_q;
	logic [9:0] held_q;

	rrt_mem_if mem_bus ();

	rrt_mem #(
		.DEPTH (RAM_DEPTH)
	) u_mem (
		.i_clk (i_clk),
		.mem   (mem_bus)
	);

	initial begin
		if (RAM_DEPTH < 1 || RAM_DEPTH > (1 << RRT_RAM_AW))
			$error("rrt_top: unsupported memory depth");
	end

	function automatic logic [9:0] ptr_addr(input logic [1:0] z,
		input logic [3:0] x, input logic [3:0] y);
		ptr_addr = {z, x, y};
	endfunction

	function automatic logic [3:0] nib_inc(input logic [3:0] v);
		nib_inc = v + NIB_ONE;
	endfunction

	function automatic logic [3:0] nib_dec(input logic [3:0] v);
		nib_dec = v - NIB_ONE;
	endfunction

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	// Memory load and exchange forms take a second clock for the registered RAM read, so
	// the instruction is held while busy is high; the core counts this
	// as one instruction cycle.
	wire [9:0] op        = (state_q == RRT_MEMWAIT) ? held_q : i_instr;
	wire       live      = i_instr_valid && (state_q == RRT_FETCH);
	wire [3:0] imm       = op[3:0];
	wire       is_pair   = op[9:8] == PFX_LOAD_PAIR;
	wire       is_bank   = op[9:2] == PFX_LOAD_BANK;
	wire       is_mld    = op[9:4] == PFX_MEM_LOAD;
	wire       is_mex    = op[9:4] == PFX_MEM_EXCH;
	wire       is_mexd   = op[9:4] == PFX_MEM_EXCH_DEC;
	wire       is_mexi   = op[9:4] == PFX_MEM_EXCH_INC;
	wire       is_mst    = op[9:4] == PFX_MEM_STORE;
	wire       is_xch    = is_mex || is_mexd || is_mexi;
	wire       is_memrd  = is_mld || is_xch;
	wire       skipping  = skip_q || (last_pair_q && is_pair);
	wire       act       = live && !skipping;
	wire [3:0] y_up      = nib_inc(y_q);
	wire [3:0] y_dn      = nib_dec(y_q);
	wire [3:0] x_xor     = x_q ^ imm;

	assign mem_bus.addr    = ptr_addr(z_q, x_q, y_q);
	assign mem_bus.wr_en   = (act && is_mst) ||
		(state_q == RRT_MEMWAIT && is_xch);
	assign mem_bus.wr_data = acc_q;

	// ------------------------------------------------------------------
	// Execute
	// ------------------------------------------------------------------
	always_comb begin
		state_d     = state_q;
		acc_d       = acc_q;
		b_d         = b_q;
		x_d         = x_q;
		y_d         = y_q;
		z_d         = z_q;
		e_d         = e_q;
		skip_d      = skip_q;
		last_pair_d = last_pair_q;
		if (state_q == RRT_MEMWAIT) begin
			state_d = RRT_FETCH;
			acc_d   = mem_bus.rd_data;
			x_d     = x_xor;
			skip_d  = 1'b0;
			if (is_mexd) begin
				y_d    = y_dn;
				skip_d = (y_dn == NIB_MAX);
			end else if (is_mexi) begin
				y_d    = y_up;
				skip_d = (y_up == NIB_ZERO);
			end
		end else if (live) begin
			skip_d      = 1'b0;
			last_pair_d = is_pair;
			if (!skipping) begin
				if (is_pair) begin
					x_d = op[7:4];
					y_d = op[3:0];
				end else if (is_bank) begin
					z_d = op[1:0];
				end else if (is_memrd) begin
					state_d = RRT_MEMWAIT;
				end else if (is_mst) begin
					x_d = x_xor;
				end else begin
					case (op)
						OP_COPY_B_TO_ACC:    acc_d = b_q;
						OP_COPY_ACC_TO_B:    b_d = acc_q;
						OP_COPY_ROW_TO_ACC:  acc_d = y_q;
						OP_COPY_ACC_TO_ROW:  y_d = acc_q;
						OP_PACK_TO_E:        e_d = {b_q, acc_q};
						OP_COPY_COL_TO_ACC:  acc_d = x_q;
						OP_COPY_BANK_TO_ACC: acc_d = {TWO_ZERO, z_q};
						OP_COPY_STACK_LEVEL: begin
							acc_d = {BIT_ZERO, i_stack_level};
						end
						OP_INCREMENT_ROW: begin
							y_d    = y_up;
							skip_d = (y_up == NIB_ZERO);
						end
						OP_DECREMENT_ROW: begin
							y_d    = y_dn;
							skip_d = (y_dn == NIB_MAX);
						end
						default: ;
					endcase
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q     <= RRT_FETCH;
			acc_q       <= NIB_ZERO;
			b_q         <= NIB_ZERO;
			x_q         <= NIB_ZERO;
			y_q         <= NIB_ZERO;
			z_q         <= TWO_ZERO;
			e_q         <= BYTE_ZERO;
			skip_q      <= 1'b0;
			last_pair_q <= 1'b0;
			busy_q      <= 1'b0;
			held_q      <= 10'h000;
			carry_q     <= 1'b0;
		end else begin
			state_q     <= state_d;
			acc_q       <= acc_d;
			b_q         <= b_d;
			x_q         <= x_d;
			y_q         <= y_d;
			z_q         <= z_d;
			e_q         <= e_d;
			skip_q      <= skip_d;
			last_pair_q <= last_pair_d;
			busy_q      <= (state_d == RRT_MEMWAIT);
			held_q      <= live ? i_instr : held_q;
			carry_q     <= i_carry_flag;
		end
	end

	assign o_acc        = acc_q;
	assign o_reg_b      = b_q;
	assign o_col        = x_q;
	assign o_row        = y_q;
	assign o_bank       = z_q;
	assign o_reg_e      = e_q;
	assign o_carry_flag = carry_q;
	assign o_skip_next  = skip_q;
	assign o_busy       = busy_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_bank_copy_acc: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		act && op == OP_COPY_BANK_TO_ACC |=> o_acc == {2'b00, $past(z_q)})
		else $error("bank copy wrong");
	a_stack_copy_acc: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		act && op == OP_COPY_STACK_LEVEL |=>
		o_acc == {1'b0, $past(i_stack_level)})
		else $error("stack level copy wrong");
	a_pair_load_xy: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		act && is_pair |=> o_col == $past(i_instr[7:4]) &&
		o_row == $past(i_instr[3:0]))
		else $error("pointer pair load wrong");
	a_pair_chain_skip: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		live && is_pair && last_pair_q |=> $stable(o_col) && $stable(o_row))
		else $error("chained pair load executed");
	a_inc_row_skip: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		act && op == OP_INCREMENT_ROW |=>
		o_row == $past(y_q) + 4'h1 && o_skip_next == (o_row == 4'h0))
		else $error("increment row wrong");
	a_dec_row_skip: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		act && op == OP_DECREMENT_ROW |=>
		o_row == $past(y_q) - 4'h1 && o_skip_next == (o_row == 4'hf))
		else $error("decrement row wrong");
	a_skip_blocks_op: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		live && skip_q |=> $stable(o_acc) && !o_skip_next && !o_busy)
		else $error("skipped instruction acted");
	a_store_xor_col: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		act && is_mst |-> mem_bus.wr_en ##1 o_col == ($past(x_q) ^ $past(imm)))
		else $error("memory store wrong");
	a_exch_two_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		act && is_xch |=> o_busy ##1 !o_busy)
		else $error("exchange timing wrong");
	a_pack_e: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		act && op == OP_PACK_TO_E |=> o_reg_e == {$past(b_q), $past(acc_q)})
		else $error("pack to E wrong");

	a_bank_load_z: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		act && is_bank |=> o_bank == $past(i_instr[1:0]))
		else $error("load bank wrong");

	a_load_xor_col: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		act && is_mld |-> ##2 o_col == ($past(x_q, 2) ^ $past(imm, 2)))
		else $error("memory load X update wrong");

	a_exch_write_acc: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		act && is_xch |=> mem_bus.wr_en && mem_bus.wr_data == $past(acc_q))
		else $error("exchange write wrong");

	a_exch_keep_bank: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		act && is_xch |-> ##2 o_bank == $past(z_q, 2))
		else $error("exchange changed bank");

	a_exch_dec_row: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		act && is_mexd |-> ##2 o_row == $past(y_q, 2) - 4'h1)
		else $error("exchange decrement row wrong");

	a_exch_inc_row: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		act && is_mexi |-> ##2 o_row == $past(y_q, 2) + 4'h1)
		else $error("exchange increment row wrong");

	a_exch_dec_skip: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		act && is_mexd |-> ##2 o_skip_next == (o_row == NIB_MAX))
		else $error("exchange decrement skip wrong");

	a_exch_inc_skip: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		act && is_mexi |-> ##2 o_skip_next == (o_row == NIB_ZERO))
		else $error("exchange increment skip wrong");

	a_copy_b_acc: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		act && op == OP_COPY_B_TO_ACC |=> o_acc == $past(b_q))
		else $error("copy B to acc wrong");

	a_copy_acc_b: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		act && op == OP_COPY_ACC_TO_B |=> o_reg_b == $past(acc_q))
		else $error("copy acc to B wrong");

	a_copy_row_acc: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		act && op == OP_COPY_ROW_TO_ACC |=> o_acc == $past(y_q))
		else $error("copy row to acc wrong");

	a_copy_acc_row: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		act && op == OP_COPY_ACC_TO_ROW |=> o_row == $past(acc_q))
		else $error("copy acc to row wrong");

	a_carry_pass: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		1'b1 |=> o_carry_flag == $past(i_carry_flag))
		else $error("carry flag changed");

	a_busy_one_cycle: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		o_busy |=> !o_busy)
		else $error("busy held too long");

	a_store_no_busy: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		act && is_mst |=> !o_busy)
		else $error("memory store stalled");

	a_skip_keeps_ptr: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		live && skip_q |=> $stable(o_row) && $stable(o_col))
		else $error("skipped instruction moved pointer");
endmodule

// ---- rrt_core_side.sv ----
// Core side model: stack level and carry sources for the decoder
`timescale 1ns/1ns
module rrt_core_side (
	input  wire logic       i_clk,
	output logic      [2:0] o_stack_level,
	output logic            o_carry_flag
);
	// Both move every cycle so a stale capture in the decoder shows up
	initial begin
		o_stack_level = 3'h0;
		o_carry_flag = 1'b0;
	end
	always @(posedge i_clk) begin
		o_stack_level <= 3'($urandom_range(0, 7));
		o_carry_flag <= 1'($urandom);
	end
endmodule

// ---- testbench.sv ----
// Testbench: transfer decoder against a behavioural reference
`timescale 1ns/1ns
module testbench
	import rrt_pkg::*;
;
	logic       i_clk = 1'b0;
	logic       i_rst_b = 1'b0;
	logic       i_instr_valid = 1'b0;
	logic [9:0] i_instr = 10'h000;
	logic [2:0] i_stack_level;
	logic       i_carry_flag;
	logic [3:0] o_acc, o_reg_b, o_col, o_row;
	logic [1:0] o_bank;
	logic [7:0] o_reg_e;
	logic       o_carry_flag, o_skip_next, o_busy;
	int         bad_count, total_checks;
	int         acc, b, x, y, z, e, skip, pp;
	int         mem [int];
	logic [9:0] fix_ops [10] = '{OP_COPY_B_TO_ACC, OP_COPY_ACC_TO_B,
		OP_COPY_ROW_TO_ACC, OP_COPY_ACC_TO_ROW, OP_PACK_TO_E,
		OP_COPY_BANK_TO_ACC, OP_COPY_COL_TO_ACC, OP_COPY_STACK_LEVEL,
		OP_INCREMENT_ROW, OP_DECREMENT_ROW};
	logic [5:0] mem_pfx [5] = '{PFX_MEM_LOAD, PFX_MEM_EXCH,
		PFX_MEM_EXCH_DEC, PFX_MEM_EXCH_INC, PFX_MEM_STORE};
	// Wraps, skips, back to back pair loads, then memory round trips
	logic [9:0] dir_ops [18] = '{10'h33f, 10'h013, 10'h01f, 10'h017,
		10'h01e, 10'h312, 10'h345, 10'h367, 10'h050, 10'h04a, 10'h053,
		10'h2b0, 10'h2f0, 10'h31f, 10'h2b0, 10'h2e0, 10'h01e, 10'h01a};

	rrt_top DUT (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_instr_valid(i_instr_valid), .i_instr(i_instr),
		.i_stack_level(i_stack_level), .i_carry_flag(i_carry_flag),
		.o_acc(o_acc), .o_reg_b(o_reg_b), .o_col(o_col), .o_row(o_row),
		.o_bank(o_bank), .o_reg_e(o_reg_e), .o_carry_flag(o_carry_flag),
		.o_skip_next(o_skip_next), .o_busy(o_busy));
	rrt_core_side PART (.i_clk(i_clk), .o_stack_level(i_stack_level),
		.o_carry_flag(i_carry_flag));

	initial forever #10 i_clk = ~i_clk;

	// ------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] ex,
		input logic [7:0] got);
		total_checks++;
		if (got !== ex) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, ex, got);
		end
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Reference model
	// ------------------------------------------------------------
	task automatic model(input logic [9:0] w, input int sl);
		int j, a, t;
		j = w[3:0];
		a = z * 256 + x * 16 + y;
		if (skip != 0 || (w[9:8] == PFX_LOAD_PAIR && pp != 0)) begin
			skip = 0;
		end else if (w[9:8] == PFX_LOAD_PAIR) begin
			x = w[7:4];
			y = w[3:0];
		end else if (w[9:2] == PFX_LOAD_BANK) begin
			z = w[1:0];
		end else if (w[9:4] == PFX_MEM_STORE) begin
			mem[a] = acc;
			x = x ^ j;
		end else if (w[9:4] == PFX_MEM_LOAD) begin
			acc = mem[a];
			x = x ^ j;
		end else if (w[9:6] == 4'hb) begin
			t = mem[a];
			mem[a] = acc;
			acc = t;
			x = x ^ j;
			if (w[9:4] == PFX_MEM_EXCH_DEC) y = (y + 15) % 16;
			if (w[9:4] == PFX_MEM_EXCH_DEC) skip = (y == 15);
			if (w[9:4] == PFX_MEM_EXCH_INC) y = (y + 1) % 16;
			if (w[9:4] == PFX_MEM_EXCH_INC) skip = (y == 0);
		end else begin
			case (w)
				OP_COPY_B_TO_ACC: acc = b;
				OP_COPY_ACC_TO_B: b = acc;
				OP_COPY_ROW_TO_ACC: acc = y;
				OP_COPY_ACC_TO_ROW: y = acc;
				OP_PACK_TO_E: e = b * 16 + acc;
				OP_COPY_BANK_TO_ACC: acc = z;
				OP_COPY_COL_TO_ACC: acc = x;
				OP_COPY_STACK_LEVEL: acc = sl;
				OP_INCREMENT_ROW: y = (y + 1) % 16;
				OP_DECREMENT_ROW: y = (y + 15) % 16;
				default: ;
			endcase
			if (w == OP_INCREMENT_ROW) skip = (y == 0);
			if (w == OP_DECREMENT_ROW) skip = (y == 15);
		end
		pp = (w[9:8] == PFX_LOAD_PAIR);
	endtask

	// ------------------------------------------------------------
	// Driving one instruction and comparing every result
	// ------------------------------------------------------------
	task automatic exec(input logic [9:0] w);
		int sl;
		@(posedge i_clk);
		i_instr_valid <= 1'b1;
		i_instr <= w;
		@(posedge i_clk);
		sl = i_stack_level;
		i_instr_valid <= 1'b0;
		model(w, sl);
		#1;
		if (o_busy === 1'b1) begin
			@(posedge i_clk);
			#1;
		end
		chk("acc", 8'(acc), {4'h0, o_acc});
		chk("b", 8'(b), {4'h0, o_reg_b});
		chk("col", 8'(x), {4'h0, o_col});
		chk("row", 8'(y), {4'h0, o_row});
		chk("bank", 8'(z), {6'h00, o_bank});
		chk("e", 8'(e), o_reg_e);
		chk("busy", 8'h00, {7'h00, o_busy});
		chk("skip", 8'(skip), {7'h00, o_skip_next});
	endtask

	// Reads of never written memory are turned into stores
	function automatic logic [9:0] rand_op();
		int k;
		logic [9:0] w;
		k = $urandom_range(0, 17);
		if (k < 10) w = fix_ops[k];
		else if (k == 10) w = {2'h3, 8'($urandom)};
		else if (k == 11) w = {PFX_LOAD_BANK, 2'($urandom)};
		else if (k == 17) w = 10'h02a;
		else w = {mem_pfx[k - 12], 4'($urandom)};
		if (k > 11 && k < 16 && !mem.exists(z * 256 + x * 16 + y))
			w = {PFX_MEM_STORE, w[3:0]};
		return w;
	endfunction

	// ------------------------------------------------------------
	// Carry pass through, watched on every edge out of reset
	// ------------------------------------------------------------
	always @(posedge i_clk) begin
		logic cf, rs;
		cf = i_carry_flag;
		rs = i_rst_b;
		#1;
		if (rs && i_rst_b) chk("carry", {7'h00, cf}, {7'h00, o_carry_flag});
	end

	initial begin
		#800000;
		bad_count++;
		$display("test watchdog expired");
		stop_test();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(44));
		repeat (6) @(posedge i_clk);
		chk("rst_ab", 8'h00, {o_acc, o_reg_b});
		chk("rst_xy", 8'h00, {o_col, o_row});
		chk("rst_e", 8'h00, o_reg_e);
		chk("rst_f", 8'h00, {3'h0, o_bank, o_carry_flag, o_skip_next, o_busy});
		i_rst_b <= 1'b1;
		$display("test reset done");
		foreach (dir_ops[i]) exec(dir_ops[i]);
		$display("test directed done");
		repeat (3000) exec(rand_op());
		$display("test random done");
		stop_test();
	end
endmodule
